// ===== logic/tspm_engine.sv
// Table search and pointer move engine with AHB-Lite register slave
// ******************************************************************
// Overview of operation
// R1: Find first table word above operand
// R2: Sequencer supplies table length beforehand
// R3: Sequencer loads table start address first
// R4: Search always begins at first word
// R5: Match returns offset into accumulator
// R6: No match gives zero and not-found
// R7: Search result pointer starts at zero
// R8: Flags valid until reuse or scan end
// R9: Move copies selected word, pointer plus one
// R10: First table word holds the pointer
// R11: Move runs each scan while enabled
// R12: Pointer at length wraps to one
// R13: Pointer zero selects first data word
// R14: Move length limited to FF; the code takes any 16-bit length with no limit
// R15: Start address is pointer, not data
// R16: Limit flag cleared at end of scan
// R17: Remove copies word, pointer minus one
// R18: Remove does nothing at pointer zero
// R19: Program presets pointer only once
// R20: Edge pulse gives single transfer
// R21: Increment limit flag when pointer equals length
// R22: Remove limit flag when pointer is zero
// R23: Remove pointer one selects first data word
// R24: Search ascending, stop at match or length
// R25: Done raised once results are updated
// R26: Pointer read, data moved, pointer written back
// ******************************************************************
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tspm_engine
(
  input  wire logic        hclk,      // Clock, 100 MHz
  input  wire logic        hresetn,   // Async reset, active low
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write when high
  input  wire logic [2:0]  hsize,     // Only word used
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready in
  output logic      [31:0] hrdata,    // Read data, registered
  output logic             hreadyout, // Always ready
  output logic             hresp,     // Always OKAY
  output logic             done_o,    // Operation finished pulse
  output logic             not_found_flag,   // Search miss flag
  output logic             table_limit_flag  // Pointer limit flag
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  tspm_mem_if mif ();
  tspm_pkg::tspm_state_t st_r, st_nxt;
  tspm_pkg::tspm_op_t    op_r;
  logic [15:0] tbase_r, tlen_r, opnd_r, dest_r, acc_r;
  logic [15:0] idx_r, ptr_r, maddr_r;
  logic        busy_r, nf_r, lim_r, done_r, doneflag_r;
  logic        wr_ph_r;
  logic [7:0]  aph_addr_r;
  logic        pwb_r;       // Pointer write-back due in DONE

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Address phase accepted on NONSEQ/SEQ with ready high
  wire         aph_ok   = hsel & hready & htrans[1];
  wire         wr_ctrl  = wr_ph_r & (aph_addr_r == tspm_pkg::ADDR_CTRL);
  wire         wr_scan  = wr_ph_r & (aph_addr_r == tspm_pkg::ADDR_SCAN);
  wire         wr_mdata = wr_ph_r & (aph_addr_r == tspm_pkg::ADDR_MDATA);
  wire         go       = wr_ctrl & hwdata[tspm_pkg::CTRL_GO_BIT] & ~busy_r;
  wire [1:0]   go_op    = hwdata[1:0];
  wire [15:0]  stat_w   = {12'h000, doneflag_r, busy_r, lim_r, nf_r};

  // Read mux, unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      tspm_pkg::ADDR_CTRL:  rd_mux = {30'h0, op_r};
      tspm_pkg::ADDR_TBASE: rd_mux = {16'h0000, tbase_r};
      tspm_pkg::ADDR_TLEN:  rd_mux = {16'h0000, tlen_r};
      tspm_pkg::ADDR_OPND:  rd_mux = {16'h0000, opnd_r};
      tspm_pkg::ADDR_DEST:  rd_mux = {16'h0000, dest_r};
      tspm_pkg::ADDR_ACC:   rd_mux = {16'h0000, acc_r};
      tspm_pkg::ADDR_STAT:  rd_mux = {16'h0000, stat_w};
      tspm_pkg::ADDR_MDATA: rd_mux = {16'h0000, mif.rdata};
      tspm_pkg::ADDR_MADDR: rd_mux = {16'h0000, maddr_r};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Engine datapath
  // ****************************************************************
  wire [15:0] ptr_w    = mif.rdata;                         // [R10]
  // Zero and length both map to the first data word
  wire [15:0] ttd_sel  = (ptr_r == tlen_r) ? 16'h0000 : ptr_r; // [R13]
  wire [15:0] ttd_addr = tbase_r + 16'h0001 + ttd_sel;      // [R15]
  wire [15:0] rfb_addr = tbase_r + ptr_r;                   // [R23]
  // Wrap to one after length, else plus one
  wire [15:0] ttd_next = (ptr_r == tlen_r) ? tspm_pkg::PTR_ONE
                                           : ptr_r + 16'h0001; // [R12]
  wire [15:0] rfb_next = ptr_r - 16'h0001;                  // [R17]
  wire [15:0] new_ptr  = (op_r == tspm_pkg::OP_RFB) ? rfb_next : ttd_next;
  wire        gt_hit   = mif.rdata > opnd_r;                // [R1]
  wire        srch_end = (idx_r + 16'h0001) >= tlen_r;      // [R24]
  // Pointer word rewritten in DONE, only after a data transfer
  wire        ptr_wb   = (st_r == tspm_pkg::ST_DONE) & pwb_r; // [R26]

  // Memory port: bus window when idle, engine when busy
  logic [15:0] ma;
  always_comb
  begin
    ma = maddr_r;
    case (st_r)
      tspm_pkg::ST_SRCH: ma = tbase_r + idx_r;
      tspm_pkg::ST_PRD:  ma = tbase_r;
      tspm_pkg::ST_COPY: ma = (op_r == tspm_pkg::OP_RFB) ? rfb_addr
                                                         : ttd_addr;
      tspm_pkg::ST_PWR:  ma = dest_r;
      tspm_pkg::ST_DONE: ma = pwb_r ? tbase_r : maddr_r;    // [R26]
      default:           ma = maddr_r;
    endcase
  end
  assign mif.addr  = ma[tspm_pkg::AW-1:0];
  assign mif.we    = (st_r == tspm_pkg::ST_PWR) | ptr_wb
                     | (wr_mdata & ~busy_r);
  assign mif.wdata = ptr_wb ? new_ptr
                     : (st_r == tspm_pkg::ST_PWR) ? acc_r : hwdata[15:0];

  tspm_mem u_mem
  (
    .hclk (hclk),
    .m    (mif.slave)
  );

  // ****************************************************************
  // State machine
  // ****************************************************************
  // Next state per operation
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      tspm_pkg::ST_IDLE:
        if (go && go_op == tspm_pkg::OP_GT)
          st_nxt = (hwdata[15:0] == 16'h0000 && tlen_r == 16'h0000)
                   ? tspm_pkg::ST_DONE : tspm_pkg::ST_SRCH;
        else if (go && go_op != tspm_pkg::OP_NONE)
          st_nxt = tspm_pkg::ST_PRD;
      tspm_pkg::ST_SRCH:
        if (gt_hit || srch_end || tlen_r == 16'h0000)
          st_nxt = tspm_pkg::ST_DONE;                        // [R24]
      tspm_pkg::ST_PRD:
        if (op_r == tspm_pkg::OP_RFB && ptr_w == 16'h0000)
          st_nxt = tspm_pkg::ST_DONE;                        // [R18]
        else
          st_nxt = tspm_pkg::ST_COPY;
      tspm_pkg::ST_COPY: st_nxt = tspm_pkg::ST_PWR;
      tspm_pkg::ST_PWR:  st_nxt = tspm_pkg::ST_DONE;
      tspm_pkg::ST_DONE: st_nxt = tspm_pkg::ST_IDLE;
      default:           st_nxt = tspm_pkg::ST_IDLE;
    endcase
  end

  // State and control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r    <= tspm_pkg::ST_IDLE;
      op_r    <= tspm_pkg::OP_NONE;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
      pwb_r   <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      done_r  <= (st_r == tspm_pkg::ST_DONE);                // [R25]
      pwb_r   <= (st_r == tspm_pkg::ST_PWR);                 // [R26]
      busy_r  <= (st_nxt != tspm_pkg::ST_IDLE);
      if (go)
        op_r  <= tspm_pkg::tspm_op_t'(go_op);                // [R11]
    end
  end

  // Search index and pointer handling
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idx_r <= tspm_pkg::ZERO16;
      ptr_r <= tspm_pkg::ZERO16;
    end
    else if (go)
      idx_r <= tspm_pkg::ZERO16;                             // [R4]
    else if (st_r == tspm_pkg::ST_SRCH)
      idx_r <= idx_r + 16'h0001;
    else if (st_r == tspm_pkg::ST_PRD)
      ptr_r <= ptr_w;                                        // [R26]
  end

  // Accumulator and result; copy word parked in acc until dest write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      acc_r <= tspm_pkg::ZERO16;
    else if (go && go_op == tspm_pkg::OP_GT)
      acc_r <= tspm_pkg::ZERO16;                             // [R7]
    else if (st_r == tspm_pkg::ST_SRCH && gt_hit)
      acc_r <= idx_r;                                        // [R5]
    else if (st_r == tspm_pkg::ST_COPY)
      acc_r <= mif.rdata;                                    // [R9]
  end

  // Flags: set wins over end-of-scan clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nf_r       <= 1'b0;
      lim_r      <= 1'b0;
      doneflag_r <= 1'b0;
    end
    else
    begin
      if (st_r == tspm_pkg::ST_SRCH && !gt_hit
          && (srch_end || tlen_r == 16'h0000))
        nf_r <= 1'b1;                                        // [R6]
      else if (go && go_op == tspm_pkg::OP_GT)
        nf_r <= 1'b0;                                        // [R8]
      else if (wr_scan)
        nf_r <= 1'b0;                                        // [R8]
      if (st_r == tspm_pkg::ST_PRD && op_r == tspm_pkg::OP_RFB
          && ptr_w == 16'h0000)
        lim_r <= 1'b1;                                       // [R22]
      else if (st_r == tspm_pkg::ST_PWR)
        lim_r <= (new_ptr == (op_r == tspm_pkg::OP_RFB
                  ? 16'h0000 : tlen_r));                     // [R21]
      else if (go && go_op != tspm_pkg::OP_GT)
        lim_r <= 1'b0;
      else if (wr_scan)
        lim_r <= 1'b0;                                       // [R16]
      if (st_r == tspm_pkg::ST_DONE)
        doneflag_r <= 1'b1;
      else if (go)
        doneflag_r <= 1'b0;
    end
  end

  // Operand registers, writable only while idle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tbase_r <= tspm_pkg::ZERO16;
      tlen_r  <= tspm_pkg::ZERO16;
      opnd_r  <= tspm_pkg::ZERO16;
      dest_r  <= tspm_pkg::ZERO16;
      maddr_r <= tspm_pkg::ZERO16;
    end
    else if (wr_ph_r && !busy_r)
    begin
      case (aph_addr_r)
        tspm_pkg::ADDR_TBASE: tbase_r <= hwdata[15:0];       // [R3]
        tspm_pkg::ADDR_TLEN:  tlen_r  <= hwdata[15:0];       // [R2]
        tspm_pkg::ADDR_OPND:  opnd_r  <= hwdata[15:0];
        tspm_pkg::ADDR_DEST:  dest_r  <= hwdata[15:0];
        tspm_pkg::ADDR_MADDR: maddr_r <= hwdata[15:0];
        default:              maddr_r <= maddr_r;
      endcase
    end
  end

  // Pointer lives only in the table's first word; no copy is kept
  // between operations, so a software preset always takes effect.

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Address phase capture, zero wait state, OKAY only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph_r    <= 1'b0;
      aph_addr_r <= 8'h00;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      done_o     <= 1'b0;
      not_found_flag   <= 1'b0;
      table_limit_flag <= 1'b0;
    end
    else
    begin
      wr_ph_r    <= aph_ok & hwrite;
      aph_addr_r <= haddr[7:0];
      hrdata     <= (aph_ok & ~hwrite) ? rd_mux : 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      done_o     <= done_r;
      not_found_flag   <= nf_r;
      table_limit_flag <= lim_r;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  done_after_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == tspm_pkg::ST_DONE) |=> done_r)                  // [R25]
    else $error("done not raised after operation");
  miss_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(nf_r) |-> acc_r == 16'h0000)                      // [R6]
    else $error("miss left nonzero accumulator");
  rfb_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == tspm_pkg::ST_PRD && op_r == tspm_pkg::OP_RFB
     && ptr_w == 16'h0000) |=> !mif.we)                      // [R18]
    else $error("remove moved data at zero pointer");
  wrap_one_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == tspm_pkg::ST_PWR && op_r == tspm_pkg::OP_TTD
     && ptr_r == tlen_r) |-> new_ptr == 16'h0001)           // [R12]
    else $error("pointer did not wrap to one");
  scan_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_scan && st_r == tspm_pkg::ST_IDLE) |=> !lim_r)      // [R16]
    else $error("limit flag survived scan end");
  hit_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == tspm_pkg::ST_SRCH && gt_hit) |=> acc_r == $past(idx_r)
     ##1 done_r)                                             // [R5]
    else $error("hit offset wrong");
  srch_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
    go |=> idx_r == 16'h0000)                                // [R4]
    else $error("search did not start at zero");
  okay_resp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 (hreadyout && !hresp))
    else $error("bus answer not ready OKAY");
  ptr_back_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r == tspm_pkg::ST_PWR) |=> (mif.we && mif.wdata == new_ptr
     && mif.addr == tbase_r[tspm_pkg::AW-1:0]))               // [R26]
    else $error("pointer word not written back");
endmodule : tspm_engine
`default_nettype wire

// ===== logic/tspm_mem.sv
// Word memory with asynchronous read and synchronous write
`timescale 1ns/1ps
`default_nettype none
module tspm_mem
(
  input  wire logic hclk,      // System clock
  tspm_mem_if.slave m          // Memory port
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [tspm_pkg::DW-1:0] mem [tspm_pkg::MEM_WORDS];

  // Combinational read keeps each engine step one cycle
  assign m.rdata = mem[m.addr];

  // Write port
  always_ff @(posedge hclk)
  begin
    if (m.we)
      mem[m.addr] <= m.wdata;
  end
endmodule : tspm_mem
`default_nettype wire

// ===== logic/tspm_mem_if.sv
// Interface: word memory port between engine and memory
`timescale 1ns/1ps
`default_nettype none
interface tspm_mem_if;
  logic [tspm_pkg::AW-1:0] addr;  // Word address
  logic                    we;    // Write strobe
  logic [tspm_pkg::DW-1:0] wdata; // Write data
  logic [tspm_pkg::DW-1:0] rdata; // Read data, same cycle
  modport master (output addr, output we, output wdata, input rdata);
  modport slave  (input addr, input we, input wdata, output rdata);
endinterface : tspm_mem_if
`default_nettype wire

// ===== logic/tspm_pkg.sv
// Package: constants and types for the table search and pointer move engine
`default_nettype none
package tspm_pkg;
  // ****************************************************************
  // Register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0]  ADDR_CTRL    = 8'h00; // Op, go
  localparam logic [7:0]  ADDR_TBASE   = 8'h04; // Table start (accumulator)
  localparam logic [7:0]  ADDR_TLEN    = 8'h08; // Table length (stack 1)
  localparam logic [7:0]  ADDR_OPND    = 8'h0C; // Search operand
  localparam logic [7:0]  ADDR_DEST    = 8'h10; // Destination address
  localparam logic [7:0]  ADDR_ACC     = 8'h14; // Accumulator result (RO)
  localparam logic [7:0]  ADDR_STAT    = 8'h18; // Flags, busy, done (RO)
  localparam logic [7:0]  ADDR_SCAN    = 8'h1C; // End-of-scan strobe (WO)
  localparam logic [7:0]  ADDR_MDATA   = 8'h20; // Memory data window
  localparam logic [7:0]  ADDR_MADDR   = 8'h24; // Memory address window
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_GO_BIT    = 4;
  localparam int STAT_NF_BIT    = 0;
  localparam int STAT_LIM_BIT   = 1;
  localparam int STAT_BUSY_BIT  = 2;
  localparam int STAT_DONE_BIT  = 3;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int AW = 10;              // Word memory address width
  localparam int DW = 16;              // Memory word width
  localparam int MEM_WORDS = 1024;
  localparam logic [15:0] PTR_ONE  = 16'h0001;
  localparam logic [15:0] ZERO16   = 16'h0000;
  // Operation codes
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_GT   = 2'b01,                   // greater_than_search_op
    OP_TTD  = 2'b10,                   // table_to_dest_move_op
    OP_RFB  = 2'b11                    // remove_bottom_op
  } tspm_op_t;
  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SRCH  = 3'b001,
    ST_PRD   = 3'b010,
    ST_COPY  = 3'b011,
    ST_PWR   = 3'b100,
    ST_DONE  = 3'b101
  } tspm_state_t;
endpackage : tspm_pkg
`default_nettype wire

// ===== test/table_search_and_pointer_move_test.sv
// Testbench: bus-driven checks of search, move and remove operations
`timescale 1ns/1ps
`default_nettype none
module table_search_and_pointer_move_test;
  // ****************************************************************
  // Signals, stimulus tables and instances
  // ****************************************************************
  logic        hclk;             // Clock
  logic        hresetn;          // Reset, active low
  logic        hsel;             // Select
  logic [31:0] haddr;            // Address
  logic [1:0]  htrans;           // Transfer type
  logic        hwrite;           // Write flag
  logic [2:0]  hsize;            // Size
  logic [31:0] hwdata;           // Write data
  logic [31:0] hrdata;           // Read data
  logic        hreadyout;        // Slave ready
  logic        hresp;            // Response
  logic        done_o;           // Finish pulse
  logic        not_found_flag;   // Search miss
  logic        table_limit_flag; // Pointer limit
  logic        hang;             // Bus wait ran out
  logic [31:0] q;                // Scratch read value
  int          failures;         // Mismatches
  int          tests_run;        // Comparisons
  // Word beyond the length is FFFF so a runaway search shows up
  logic [15:0] tbl [5] = '{16'h2, 16'h3, 16'h9, 16'h4, 16'hFFFF};
  logic [15:0] sop [5] = '{16'h9, 16'h4, 16'h1, 16'h3, 16'h9};
  logic [15:0] sacc [5] = '{16'h0, 16'h2, 16'h0, 16'h2, 16'h0};
  logic [4:0]  snf = 5'b10001;
  logic [15:0] tdst [4] = '{16'hA1, 16'hA2, 16'hA3, 16'hA1};
  logic [15:0] tptr [4] = '{16'h1, 16'h2, 16'h3, 16'h1};
  logic [15:0] rdst [3] = '{16'hB2, 16'hB1, 16'hB1};
  logic [15:0] rptr [3] = '{16'h1, 16'h0, 16'h0};
  tspm_engine uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .done_o(done_o),
    .not_found_flag(not_found_flag), .table_limit_flag(table_limit_flag));
  tspm_seq_model seq (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hang(hang));
  // Free-running 100 MHz clock
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("Counts: %0d comparisons, %0d mismatches", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", what, e, g);
      failures++;
    end
  endtask : check
  // A hung handshake ends the run at once
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    seq.bus_xfer(w, a, d, q);
    if (hang === 1'b1)
    begin
      $display("Error bus ready expected 1 seen none");
      failures++;
      report_and_stop();
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic mem_wr(input logic [31:0] a, input logic [15:0] d);
    wr(tspm_pkg::ADDR_MADDR, a);
    wr(tspm_pkg::ADDR_MDATA, {16'h0, d});
  endtask : mem_wr
  task automatic mem_chk(input string what, input logic [31:0] a,
                         input logic [15:0] e);
    wr(tspm_pkg::ADDR_MADDR, a);
    xfer(1'b0, tspm_pkg::ADDR_MDATA, 32'h0);
    check(what, {16'h0, e}, q);
  endtask : mem_chk
  // Flags seen both in the status word and on the pins
  task automatic flags_chk(input logic nf, input logic lim);
    xfer(1'b0, tspm_pkg::ADDR_STAT, 32'h0);
    check("not found bit", {31'h0, nf}, {31'h0, q[tspm_pkg::STAT_NF_BIT]});
    check("limit bit", {31'h0, lim}, {31'h0, q[tspm_pkg::STAT_LIM_BIT]});
    check("not found pin", {31'h0, nf}, {31'h0, not_found_flag});
    check("limit pin", {31'h0, lim}, {31'h0, table_limit_flag});
  endtask : flags_chk
  // Start one operation and wait, bounded, for its done pulse
  task automatic run_op(input tspm_pkg::tspm_op_t op);
    int n;
    n = 0;
    wr(tspm_pkg::ADDR_CTRL, (32'h1 << tspm_pkg::CTRL_GO_BIT) | {30'h0, op});
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (done_o !== 1'b1 && n < 600);
    if (done_o !== 1'b1)
    begin
      $display("Error done pulse expected 1 seen none");
      failures++;
      report_and_stop();
    end
  endtask : run_op
  // One scan of a pointer operation, ending with the end-of-scan strobe
  task automatic move_step(input tspm_pkg::tspm_op_t op,
      input logic [15:0] ed, input logic [15:0] ep, input logic el,
      input logic [31:0] dst, input logic [31:0] pw);
    run_op(op);
    mem_chk("destination word", dst, ed);
    mem_chk("pointer word", pw, ep);
    flags_chk(1'b0, el);
    wr(tspm_pkg::ADDR_SCAN, 32'h0);
  endtask : move_step
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    failures = 0;
    tests_run = 0;
    hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    check("ready after reset", 32'h1, {31'h0, hreadyout});
    xfer(1'b0, tspm_pkg::ADDR_ACC, 32'h0);
    check("accumulator after reset", 32'h0, q);
    xfer(1'b0, tspm_pkg::ADDR_STAT, 32'h0);
    check("status after reset", 32'h0, q);
    $display("Test reset finished");
    // Search: equal is not greater, and the word past the length is unseen
    for (int i = 0; i < 5; i++)
      mem_wr(32'h100 + i, tbl[i]);
    wr(tspm_pkg::ADDR_TBASE, 32'h100);
    wr(tspm_pkg::ADDR_TLEN, 32'h4);
    for (int i = 0; i < 5; i++)
    begin
      wr(tspm_pkg::ADDR_OPND, {16'h0, sop[i]});
      run_op(tspm_pkg::OP_GT);
      xfer(1'b0, tspm_pkg::ADDR_ACC, 32'h0);
      check("search offset", {16'h0, sacc[i]}, q);
      flags_chk(snf[i], 1'b0);
    end
    wr(tspm_pkg::ADDR_SCAN, 32'h0);
    flags_chk(1'b0, 1'b0);
    $display("Test search finished");
    // Move: pointer 0 and pointer 3 both pick the first data word
    mem_wr(32'h200, 16'h0);
    for (int i = 1; i < 4; i++)
      mem_wr(32'h200 + i, tdst[i - 1]);
    mem_wr(32'h204, 16'hEEEE);
    wr(tspm_pkg::ADDR_TBASE, 32'h200);
    wr(tspm_pkg::ADDR_TLEN, 32'h3);
    wr(tspm_pkg::ADDR_DEST, 32'h250);
    for (int i = 0; i < 4; i++)
      move_step(tspm_pkg::OP_TTD, tdst[i], tptr[i], i == 2, 32'h250,
        32'h200);
    $display("Test table move finished");
    // Remove: counts down to zero, then stops transferring
    mem_wr(32'h300, 16'h2);
    for (int i = 1; i < 4; i++)
      mem_wr(32'h300 + i, 16'(16'hB0 + i));
    mem_wr(32'h350, 16'h0);
    wr(tspm_pkg::ADDR_TBASE, 32'h300);
    wr(tspm_pkg::ADDR_TLEN, 32'h3);
    wr(tspm_pkg::ADDR_DEST, 32'h350);
    for (int i = 0; i < 3; i++)
      move_step(tspm_pkg::OP_RFB, rdst[i], rptr[i], i > 0, 32'h350,
        32'h300);
    $display("Test remove finished");
    // Unmapped address still completes with an OKAY response
    xfer(1'b0, 8'h30, 32'h0);
    check("response on unmapped read", 32'h0, {31'h0, hresp});
    $display("Test unmapped finished");
    report_and_stop();
  end
endmodule : table_search_and_pointer_move_test
`default_nettype wire

// ===== test/tspm_seq_model.sv
// Scan sequencer model: single-word AHB-Lite master toward the engine
`timescale 1ns/1ps
`default_nettype none
module tspm_seq_model
(
  input  wire logic        hclk,   // System clock
  input  wire logic        hready, // Bus ready
  input  wire logic [31:0] hrdata, // Read data
  output var  logic        hsel,   // Slave select
  output var  logic [31:0] haddr,  // Byte address
  output var  logic [1:0]  htrans, // Transfer type
  output var  logic        hwrite, // Write flag
  output var  logic [2:0]  hsize,  // Always word
  output var  logic [31:0] hwdata, // Write data
  output var  logic        hang    // A wait ran out
);
  // Idle bus at time zero
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0;
    hang   = 1'b0;
  end
  // Bounded wait for ready at a rising edge; no latency is assumed
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1)
      hang = 1'b1;
  endtask : wait_ready
  // One transfer; released data lines show the inverse, not a stale value
  task automatic bus_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hwdata <= ~hwdata;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wr ? d : ~hwdata;
    wait_ready();
    q = hrdata;
  endtask : bus_xfer
endmodule : tspm_seq_model
`default_nettype wire
